//--- hw/mcsr_pkg.sv
// constants shared by the monitor register front end
package mcsr_pkg;
  // ********************
  // register offsets
  // ********************
  localparam logic [7:0] OFF_CONFIG = 8'h00;
  localparam logic [7:0] OFF_STATUS_ONE = 8'h01;
  localparam logic [7:0] OFF_STATUS_TWO = 8'h02;
  localparam logic [7:0] OFF_MASK_ONE = 8'h03;
  localparam logic [7:0] OFF_MASK_TWO = 8'h04;
  localparam logic [7:0] OFF_FAN_DIV = 8'h05;
  localparam logic [7:0] OFF_TEMP_CFG = 8'h06;
  localparam logic [7:0] OFF_CONV_RATE = 8'h07;
  localparam logic [7:0] OFF_CHAN_DIS = 8'h08;
  localparam logic [7:0] OFF_RAM_LO = 8'h20;
  localparam logic [7:0] OFF_RAM_HI = 8'h3f;
  localparam logic [4:0] RAM_IDX_ID_A = 5'h1e;
  localparam logic [4:0] RAM_IDX_ID_B = 5'h1f;

  // ********************
  // reset values
  // ********************
  localparam logic [7:0] RST_POINTER = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h08;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_FAN_DIV = 8'h14;
  localparam logic [7:0] RST_TEMP_CFG = 8'h01;
  localparam logic [7:0] RST_CONV_RATE = 8'h00;
  localparam logic [7:0] RST_CHAN_DIS = 8'h00;

  // ********************
  // field positions
  // ********************
  localparam int CFG_START = 0;
  localparam int CFG_ALERT_EN = 1;
  localparam int CFG_ALERT_POL = 2;
  localparam int CFG_ALERT_DIS = 3;
  localparam int CFG_RESET_PULSE = 4;
  localparam int CFG_ENCL_CLEAR = 5;
  localparam int CFG_GPO = 6;
  localparam int CFG_RESTORE = 7;
  localparam int FAN_RST_EN = 7;
  localparam int FAN_OS_EN = 6;
  localparam int ST1_CHAIN = 7;
  localparam int ST2_ENCL = 4;

  // ********************
  // timing
  // ********************
  localparam int CLOCK_HZ = 50_000_000;
  localparam int PULSE_MS = 10;
  localparam int PULSE_CYCLES = (PULSE_MS * (CLOCK_HZ / 1000));

  // ********************
  // serial link
  // ********************
  localparam logic [6:0] SLAVE_ADDR = 7'h2c;
  // identification bytes; values are arbitrary
  localparam logic [7:0] ID_VALUE_A = 8'h5a;
  localparam logic [7:0] ID_VALUE_B = 8'ha5;

  typedef enum logic [2:0] {
    LS_IDLE, LS_ADDR, LS_ADDR_ACK, LS_WR_BYTE, LS_WR_ACK, LS_RD_BYTE, LS_RD_ACK
  } mcsr_link_state_t;
endpackage

//--- hw/mcsr_value_ram.sv
// value ram, 32 bytes, registered read data
`timescale 1ns/1ps
`default_nettype none
module mcsr_value_ram #(
  parameter logic [7:0] ID_A = mcsr_pkg::ID_VALUE_A,
  parameter logic [7:0] ID_B = mcsr_pkg::ID_VALUE_B
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_restore,
  input wire logic i_write,
  input wire logic [4:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:31];
  logic [7:0] rdata;

  // identification bytes come back on reset or restore
  always_ff @(posedge i_clock) begin
    if (i_rst || i_restore) begin
      mem[mcsr_pkg::RAM_IDX_ID_A] <= ID_A;
      mem[mcsr_pkg::RAM_IDX_ID_B] <= ID_B;
    end else if (i_write) begin
      mem[i_addr] <= i_wdata;
    end
    if (i_rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= mem[i_addr];
    end
  end

  assign o_rdata = rdata;
endmodule
`default_nettype wire

//--- hw/mcsr_regs.sv
// monitor configuration and status registers behind a two-wire serial slave
`timescale 1ns/1ps
`default_nettype none
module mcsr_regs #(
  parameter int PULSE_CYCLES = mcsr_pkg::PULSE_CYCLES,
  parameter logic [6:0] SLAVE_ADDR = mcsr_pkg::SLAVE_ADDR
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  input wire logic [6:0] i_limit_hit,
  input wire logic [7:0] i_status_two_set,
  input wire logic i_chain_alert_n,
  input wire logic i_enclosure_open_input,
  output logic o_enclosure_open_input,
  output logic o_enclosure_open_input_oe,
  output logic o_monitor_run,
  output logic o_alert,
  output logic o_alert_oe,
  output logic o_reset_out,
  output logic o_reset_out_oe,
  output logic o_general_output_pin,
  output logic o_general_output_pin_oe,
  output logic [7:0] o_fan_divider_pin_select,
  output logic [7:0] o_temp_alarm_config,
  output logic [7:0] o_conversion_rate,
  output logic [7:0] o_channel_disable
);
  localparam int CW = $clog2(PULSE_CYCLES + 1);

  // ********************
  // input synchronisers
  // ********************
  // order: scl, sda, chained alert, enclosure line
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic scl_d;
  logic sda_d;
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sync_a <= 4'he;
      sync_b <= 4'he;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      sync_a <= {i_scl, i_sda, i_chain_alert_n, i_enclosure_open_input};
      sync_b <= sync_a;
      scl_d <= sync_b[3];
      sda_d <= sync_b[2];
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  assign scl_s = sync_b[3];
  assign sda_s = sync_b[2];
  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign bus_start = scl_s && scl_d && sda_d && !sda_s;
  assign bus_stop = scl_s && scl_d && !sda_d && sda_s;

  // ********************
  // state
  // ********************
  mcsr_pkg::mcsr_link_state_t st, next_st;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] shreg, next_shreg;
  logic first_byte, next_first_byte;
  logic [7:0] pointer, next_pointer;
  logic [7:0] cfg, next_cfg;
  logic [7:0] st1, next_st1;
  logic [7:0] st2, next_st2;
  logic [7:0] msk1, next_msk1;
  logic [7:0] msk2, next_msk2;
  logic [7:0] fan, next_fan;
  logic [7:0] tcfg, next_tcfg;
  logic [7:0] rate, next_rate;
  logic [7:0] cdis, next_cdis;
  logic [CW-1:0] rst_cnt, next_rst_cnt;
  logic [CW-1:0] encl_cnt, next_encl_cnt;
  logic sda_oe, next_sda_oe;
  logic alert, next_alert;
  logic alert_oe, next_alert_oe;
  logic restore, next_restore;
  logic ram_we;
  logic [7:0] ram_rdata;
  logic [7:0] rd_byte;

  function automatic logic is_ram(input logic [7:0] a);
    return (a >= mcsr_pkg::OFF_RAM_LO) && (a <= mcsr_pkg::OFF_RAM_HI);
  endfunction

  // ********************
  // read mux
  // ********************
  always_comb begin
    if (pointer == mcsr_pkg::OFF_CONFIG) begin
      rd_byte = cfg;
    end else if (pointer == mcsr_pkg::OFF_STATUS_ONE) begin
      rd_byte = st1;
    end else if (pointer == mcsr_pkg::OFF_STATUS_TWO) begin
      rd_byte = st2;
    end else if (pointer == mcsr_pkg::OFF_MASK_ONE) begin
      rd_byte = msk1;
    end else if (pointer == mcsr_pkg::OFF_MASK_TWO) begin
      rd_byte = msk2;
    end else if (pointer == mcsr_pkg::OFF_FAN_DIV) begin
      rd_byte = fan;
    end else if (pointer == mcsr_pkg::OFF_TEMP_CFG) begin
      rd_byte = tcfg;
    end else if (pointer == mcsr_pkg::OFF_CONV_RATE) begin
      rd_byte = rate;
    end else if (pointer == mcsr_pkg::OFF_CHAN_DIS) begin
      rd_byte = cdis;
    end else if (is_ram(pointer)) begin
      rd_byte = ram_rdata;
    end else begin
      rd_byte = 8'h00;
    end
  end

  // ********************
  // next state
  // ********************
  always_comb begin
    logic wr_data;
    logic rd_load;
    logic run;
    logic pending;
    wr_data = 1'b0;
    rd_load = 1'b0;
    run = 1'b0;
    pending = 1'b0;
    next_st = st;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_first_byte = first_byte;
    next_pointer = pointer;
    next_cfg = cfg;
    next_st1 = st1;
    next_st2 = st2;
    next_msk1 = msk1;
    next_msk2 = msk2;
    next_fan = fan;
    next_tcfg = tcfg;
    next_rate = rate;
    next_cdis = cdis;
    next_rst_cnt = rst_cnt;
    next_encl_cnt = encl_cnt;
    next_sda_oe = sda_oe;
    next_restore = 1'b0;

    // serial link
    if (bus_start) begin
      next_st = mcsr_pkg::LS_ADDR;
      next_bit_cnt = 4'h0;
      next_sda_oe = 1'b0;
    end else if (bus_stop) begin
      next_st = mcsr_pkg::LS_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      case (st)
        mcsr_pkg::LS_ADDR, mcsr_pkg::LS_WR_BYTE: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sda_s};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            next_sda_oe = 1'b1;
            if (st == mcsr_pkg::LS_ADDR) begin
              next_first_byte = 1'b1;
              next_st = (shreg[7:1] == SLAVE_ADDR) ? mcsr_pkg::LS_ADDR_ACK : mcsr_pkg::LS_IDLE;
              next_sda_oe = (shreg[7:1] == SLAVE_ADDR);
            end else begin
              next_st = mcsr_pkg::LS_WR_ACK;
              next_first_byte = 1'b0;
              if (first_byte) begin
                next_pointer = shreg;
              end else begin
                wr_data = 1'b1;
              end
            end
          end
        end
        mcsr_pkg::LS_ADDR_ACK: begin
          if (scl_fall) begin
            next_bit_cnt = 4'h0;
            if (shreg[0]) begin
              next_st = mcsr_pkg::LS_RD_BYTE;
              rd_load = 1'b1;
            end else begin
              next_st = mcsr_pkg::LS_WR_BYTE;
              next_sda_oe = 1'b0;
            end
          end
        end
        mcsr_pkg::LS_WR_ACK: begin
          if (scl_fall) begin
            next_st = mcsr_pkg::LS_WR_BYTE;
            next_bit_cnt = 4'h0;
            next_sda_oe = 1'b0;
          end
        end
        mcsr_pkg::LS_RD_BYTE: begin
          if (scl_fall) begin
            if (bit_cnt == 4'h7) begin
              next_st = mcsr_pkg::LS_RD_ACK;
              next_sda_oe = 1'b0;
            end else begin
              next_shreg = {shreg[6:0], 1'b0};
              next_sda_oe = !shreg[6];
              next_bit_cnt = bit_cnt + 4'h1;
            end
          end
        end
        mcsr_pkg::LS_RD_ACK: begin
          // a nack from the host ends the read; wait for stop
          if (scl_rise && sda_s) begin
            next_st = mcsr_pkg::LS_IDLE;
          end else if (scl_fall) begin
            next_st = mcsr_pkg::LS_RD_BYTE;
            next_bit_cnt = 4'h0;
            rd_load = 1'b1;
          end
        end
        default: begin
          next_sda_oe = 1'b0;
        end
      endcase
    end
    if (rd_load) begin
      next_shreg = rd_byte;
      next_sda_oe = !rd_byte[7];
    end

    // status: clear on read, set wins over clear, frozen while disabled
    run = cfg[mcsr_pkg::CFG_START] && !cfg[mcsr_pkg::CFG_ALERT_DIS];
    if (rd_load && pointer == mcsr_pkg::OFF_STATUS_ONE) begin
      next_st1 = mcsr_pkg::RST_STATUS;
    end
    if (rd_load && pointer == mcsr_pkg::OFF_STATUS_TWO) begin
      next_st2 = mcsr_pkg::RST_STATUS;
    end
    if (run) begin
      next_st1 = next_st1 | {!sync_b[1], i_limit_hit};
      next_st2 = next_st2 | i_status_two_set | {3'b000, sync_b[0], 4'h0};
    end

    // timed pulses; bits drop when the count ends
    // counted down before host writes so a fresh write reloads the count
    if (rst_cnt != '0) begin
      next_rst_cnt = rst_cnt - CW'(1);
    end
    if (encl_cnt != '0) begin
      next_encl_cnt = encl_cnt - CW'(1);
    end
    if (cfg[mcsr_pkg::CFG_RESET_PULSE] && rst_cnt == CW'(1)) begin
      next_cfg[mcsr_pkg::CFG_RESET_PULSE] = 1'b0;
    end
    if (cfg[mcsr_pkg::CFG_ENCL_CLEAR] && encl_cnt == CW'(1)) begin
      next_cfg[mcsr_pkg::CFG_ENCL_CLEAR] = 1'b0;
    end

    // host register writes; status offsets fall through untouched
    if (wr_data) begin
      if (pointer == mcsr_pkg::OFF_CONFIG) begin
        next_cfg = shreg & 8'h7f;
        next_restore = shreg[mcsr_pkg::CFG_RESTORE];
        if (shreg[mcsr_pkg::CFG_RESET_PULSE]) begin
          next_rst_cnt = CW'(PULSE_CYCLES);
        end
        if (shreg[mcsr_pkg::CFG_ENCL_CLEAR]) begin
          next_encl_cnt = CW'(PULSE_CYCLES);
        end
      end else if (pointer == mcsr_pkg::OFF_MASK_ONE) begin
        next_msk1 = shreg;
      end else if (pointer == mcsr_pkg::OFF_MASK_TWO) begin
        next_msk2 = shreg;
      end else if (pointer == mcsr_pkg::OFF_FAN_DIV) begin
        next_fan = shreg;
      end else if (pointer == mcsr_pkg::OFF_TEMP_CFG) begin
        next_tcfg = shreg;
      end else if (pointer == mcsr_pkg::OFF_CONV_RATE) begin
        next_rate = shreg;
      end else if (pointer == mcsr_pkg::OFF_CHAN_DIS) begin
        next_cdis = shreg;
      end
    end

    // restore wins over anything else written this cycle
    if (restore) begin
      next_cfg = mcsr_pkg::RST_CONFIG;
      next_st1 = mcsr_pkg::RST_STATUS;
      next_st2 = mcsr_pkg::RST_STATUS;
      next_msk1 = mcsr_pkg::RST_MASK;
      next_msk2 = mcsr_pkg::RST_MASK;
      next_fan = mcsr_pkg::RST_FAN_DIV;
      next_tcfg = mcsr_pkg::RST_TEMP_CFG;
      next_rate = mcsr_pkg::RST_CONV_RATE;
      next_cdis = mcsr_pkg::RST_CHAN_DIS;
      next_rst_cnt = '0;
      next_encl_cnt = '0;
    end

    // alert pin, only unmasked flags count
    pending = |(st1 & ~msk1) || |(st2 & ~msk2);
    next_alert_oe = 1'b0;
    if (cfg[mcsr_pkg::CFG_ALERT_EN] && !cfg[mcsr_pkg::CFG_ALERT_DIS] && pending) begin
      next_alert_oe = 1'b1;
    end
    next_alert = cfg[mcsr_pkg::CFG_ALERT_POL];
  end

  // ********************
  // registers
  // ********************
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st <= mcsr_pkg::LS_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      first_byte <= 1'b0;
      pointer <= mcsr_pkg::RST_POINTER;
      cfg <= mcsr_pkg::RST_CONFIG;
      st1 <= mcsr_pkg::RST_STATUS;
      st2 <= mcsr_pkg::RST_STATUS;
      msk1 <= mcsr_pkg::RST_MASK;
      msk2 <= mcsr_pkg::RST_MASK;
      fan <= mcsr_pkg::RST_FAN_DIV;
      tcfg <= mcsr_pkg::RST_TEMP_CFG;
      rate <= mcsr_pkg::RST_CONV_RATE;
      cdis <= mcsr_pkg::RST_CHAN_DIS;
      rst_cnt <= '0;
      encl_cnt <= '0;
      sda_oe <= 1'b0;
      alert <= 1'b0;
      alert_oe <= 1'b0;
      restore <= 1'b0;
    end else begin
      st <= next_st;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      first_byte <= next_first_byte;
      pointer <= next_pointer;
      cfg <= next_cfg;
      st1 <= next_st1;
      st2 <= next_st2;
      msk1 <= next_msk1;
      msk2 <= next_msk2;
      fan <= next_fan;
      tcfg <= next_tcfg;
      rate <= next_rate;
      cdis <= next_cdis;
      rst_cnt <= next_rst_cnt;
      encl_cnt <= next_encl_cnt;
      sda_oe <= next_sda_oe;
      alert <= next_alert;
      alert_oe <= next_alert_oe;
      restore <= next_restore;
    end
  end

  assign ram_we = st == mcsr_pkg::LS_WR_BYTE && scl_fall && bit_cnt == 4'h8 && !first_byte && is_ram(pointer);

  mcsr_value_ram u_ram (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_restore(restore),
    .i_write(ram_we),
    .i_addr(pointer[4:0]),
    .i_wdata(shreg),
    .o_rdata(ram_rdata)
  );

  // ********************
  // pins
  // ********************
  assign o_sda = 1'b0;
  assign o_sda_oe = sda_oe;
  assign o_monitor_run = cfg[mcsr_pkg::CFG_START] && !cfg[mcsr_pkg::CFG_ALERT_DIS];
  assign o_alert = alert;
  assign o_alert_oe = alert_oe;
  assign o_reset_out = 1'b0;
  // pulse only reaches the pin when the pin is set to reset duty
  assign o_reset_out_oe = (rst_cnt != '0) && fan[mcsr_pkg::FAN_RST_EN] && !fan[mcsr_pkg::FAN_OS_EN];
  assign o_enclosure_open_input = 1'b0;
  assign o_enclosure_open_input_oe = encl_cnt != '0;
  assign o_general_output_pin = 1'b0;
  assign o_general_output_pin_oe = cfg[mcsr_pkg::CFG_GPO];
  assign o_fan_divider_pin_select = fan;
  assign o_temp_alarm_config = tcfg;
  assign o_conversion_rate = rate;
  assign o_channel_disable = cdis;
endmodule
`default_nettype wire

//--- verification/mcsr_regs_asserts.sv
// concurrent checks on the pins of the monitor register front end
`timescale 1ns/1ps
`default_nettype none
module mcsr_regs_chk #(
  parameter int PULSE_CYCLES = mcsr_pkg::PULSE_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic o_sda,
  input wire logic o_sda_oe,
  input wire logic o_monitor_run,
  input wire logic o_alert_oe,
  input wire logic o_reset_out,
  input wire logic o_reset_out_oe,
  input wire logic o_general_output_pin,
  input wire logic o_general_output_pin_oe,
  input wire logic o_enclosure_open_input,
  input wire logic o_enclosure_open_input_oe,
  input wire logic [7:0] o_fan_divider_pin_select,
  input wire logic [7:0] o_temp_alarm_config,
  input wire logic [7:0] o_conversion_rate,
  input wire logic [7:0] o_channel_disable
);
  int rst_run;
  int enc_run;
  int next_rst_run;
  int next_enc_run;
  // ********************
  // pulse run counters
  // ********************
  always_comb begin
    next_rst_run = o_reset_out_oe ? rst_run + 1 : 0;
    next_enc_run = o_enclosure_open_input_oe ? enc_run + 1 : 0;
  end
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rst_run <= 0;
      enc_run <= 0;
    end else begin
      rst_run <= next_rst_run;
      enc_run <= next_enc_run;
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  sequence sda_rise_s;
    $rose(o_sda_oe);
  endsequence
  // a driven bit must outlive the whole high phase of the serial clock
  sequence sda_hold_s;
    o_sda_oe [*6];
  endsequence
  sequence enc_rise_s;
    $rose(o_enclosure_open_input_oe);
  endsequence
  rst_pulse_len_a: assert property ($fell(o_reset_out_oe) |-> rst_run == PULSE_CYCLES)
    else $error("reset pulse length wrong");
  enc_pulse_len_a: assert property ($fell(o_enclosure_open_input_oe) |-> enc_run == PULSE_CYCLES)
    else $error("enclosure clear length wrong");
  rst_pin_gate_a: assert property ($rose(o_reset_out_oe) |->
    o_fan_divider_pin_select[7] && !o_fan_divider_pin_select[6])
    else $error("reset pulse while pin not enabled");
  drain_levels_a: assert property (!o_sda && !o_reset_out && !o_general_output_pin
    && !o_enclosure_open_input)
    else $error("open drain pin driven high");
  reset_defaults_a: assert property ($fell(i_rst) |-> o_fan_divider_pin_select == 8'h14
    && o_temp_alarm_config == 8'h01 && o_conversion_rate == 8'h00 && o_channel_disable == 8'h00 && !o_monitor_run)
    else $error("register defaults wrong after reset");
  reset_idle_a: assert property ($fell(i_rst) |-> !(o_alert_oe || o_reset_out_oe
    || o_enclosure_open_input_oe || o_general_output_pin_oe || o_sda_oe))
    else $error("pin active after reset");
  sda_hold_a: assert property (sda_rise_s |-> sda_hold_s)
    else $error("serial data bit dropped early");
  enc_hold_a: assert property (enc_rise_s |-> o_enclosure_open_input_oe [*8])
    else $error("enclosure clear too short");
endmodule
bind mcsr_regs mcsr_regs_chk #(.PULSE_CYCLES(PULSE_CYCLES)) chk_u (
  .i_clock(i_clock), .i_rst(i_rst), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_monitor_run(o_monitor_run),
  .o_alert_oe(o_alert_oe), .o_reset_out(o_reset_out), .o_reset_out_oe(o_reset_out_oe),
  .o_general_output_pin(o_general_output_pin), .o_general_output_pin_oe(o_general_output_pin_oe),
  .o_enclosure_open_input(o_enclosure_open_input), .o_enclosure_open_input_oe(o_enclosure_open_input_oe),
  .o_fan_divider_pin_select(o_fan_divider_pin_select), .o_temp_alarm_config(o_temp_alarm_config),
  .o_conversion_rate(o_conversion_rate), .o_channel_disable(o_channel_disable));
`default_nettype wire

//--- verification/mcsr_host.sv
// two-wire host model running register accesses on the serial link
`timescale 1ns/1ps
`default_nettype none
module mcsr_host (
  input wire logic i_clock,
  input wire logic i_sda_oe,
  output logic o_scl,
  output logic o_sda,
  output logic o_valid,
  output logic [11:0] o_result
);
  logic low = 1'b0;
  initial o_scl = 1'b1;
  initial o_valid = 1'b0;
  initial o_result = 12'h000;
  // pull-up: line is low while either side pulls it
  assign o_sda = !(low || i_sda_oe);
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  // ********************
  // line conditions and bytes
  // ********************
  // a then b on data with the clock high in between: 0,1 is a start, 1,0 a stop
  task automatic cond(input logic a, input logic b);
    tick(2);
    low = a;
    tick(2);
    o_scl = 1'b1;
    tick(4);
    low = b;
    tick(4);
  endtask
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      tick(2);
      low = !tx[i];
      tick(2);
      o_scl = 1'b1;
      tick(2);
      rx[i] = o_sda;
      tick(2);
      o_scl = 1'b0;
    end
  endtask
  task automatic access(input logic [6:0] dev, input logic wr, input logic [7:0] ptr, input logic [7:0] wd);
    logic [8:0] r;
    logic [3:0] nk;
    nk = 4'h0;
    o_result[7:0] = 8'h00;
    cond(1'b0, 1'b1);
    o_scl = 1'b0;
    xfer({dev, 2'b01}, r);
    nk[3] = r[0];
    xfer({ptr, 1'b1}, r);
    nk[2] = r[0];
    if (wr) begin
      xfer({wd, 1'b1}, r);
      nk[1] = r[0];
    end else begin
      cond(1'b0, 1'b1);
      o_scl = 1'b0;
      xfer({dev, 2'b11}, r);
      nk[0] = r[0];
      xfer(9'h1ff, r);
      o_result[7:0] = r[8:1];
    end
    cond(1'b1, 1'b0);
    o_result[11:8] = nk;
    o_valid = 1'b1;
    tick(1);
    o_valid = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench for the monitor register front end
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int PULSE = 20;
  localparam logic [6:0] DEV = mcsr_pkg::SLAVE_ADDR;
  localparam logic [7:0] CFG = mcsr_pkg::OFF_CONFIG;
  localparam logic [7:0] ST1 = mcsr_pkg::OFF_STATUS_ONE;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic [6:0] hit = 7'h00;
  logic chain_n = 1'b1;
  logic encl = 1'b0;
  logic [7:0] st2_set = 8'h00;
  logic [7:0] w;
  logic sda_o, encl_o, rst_o, gpo_o;
  logic scl, sda, sda_oe, valid, alert, alert_oe, run, gpo_oe, rst_oe, enc_oe;
  logic [7:0] v;
  logic [11:0] result, pins;
  logic [7:0] regs [0:8];
  logic [11:0] exp_q [$];
  logic [7:0] dflt [0:8] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h14, 8'h01, 8'h00, 8'h00};
  int n_errors = 0;
  int n_checks = 0;
  int n_rst = 0;
  int n_enc = 0;
  int seed;
  // upper bits are the open-drain data levels, which must stay low
  assign pins = {4'h0, sda_o, encl_o, rst_o, gpo_o, alert_oe, alert, run, gpo_oe};
  always #10 i_clock = ~i_clock;
  mcsr_regs #(.PULSE_CYCLES(PULSE)) dut_u (
    .i_clock(i_clock), .i_rst(i_rst), .i_scl(scl), .i_sda(sda), .o_sda(sda_o), .o_sda_oe(sda_oe),
    .i_limit_hit(hit), .i_status_two_set(st2_set), .i_chain_alert_n(chain_n), .i_enclosure_open_input(encl),
    .o_enclosure_open_input(encl_o), .o_enclosure_open_input_oe(enc_oe), .o_monitor_run(run), .o_alert(alert),
    .o_alert_oe(alert_oe), .o_reset_out(rst_o), .o_reset_out_oe(rst_oe), .o_general_output_pin(gpo_o),
    .o_general_output_pin_oe(gpo_oe), .o_fan_divider_pin_select(regs[5]), .o_temp_alarm_config(regs[6]),
    .o_conversion_rate(regs[7]), .o_channel_disable(regs[8]));
  mcsr_host host_u (.i_clock(i_clock), .i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda), .o_valid(valid),
    .o_result(result));
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ********************
  // result watcher and stimulus helpers
  // ********************
  always @(posedge i_clock) begin
    if (valid === 1'b1) check(result, exp_q.pop_front());
    if (rst_oe === 1'b1) n_rst++;
    if (enc_oe === 1'b1) n_enc++;
  end
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [11:0] e);
    exp_q.push_back(e);
    host_u.access(DEV, wr, a, d);
  endtask
  task automatic chk_dflt();
    for (int a = 0; a < 9; a++) begin
      acc(1'b0, 8'(a), 8'h00, {4'h0, dflt[a]});
    end
  endtask
  task automatic events(input logic [6:0] h, input logic c);
    hit = h;
    chain_n = c;
    host_u.tick(4);
    hit = 7'h00;
    chain_n = 1'b1;
    host_u.tick(4);
  endtask
  task automatic pulse_case(input logic [7:0] fan, input logic [7:0] cfg, input int exp);
    int r0;
    r0 = n_rst + n_enc;
    acc(1'b1, 8'h05, fan, 12'h000);
    acc(1'b1, CFG, cfg, 12'h000);
    host_u.tick(40);
    check(12'(n_rst + n_enc - r0), 12'(exp));
    acc(1'b0, CFG, 8'h00, 12'h000);
  endtask
  initial begin
    seed = $urandom(34);
    host_u.tick(12);
    i_rst = 1'b0;
    host_u.tick(3);
    chk_dflt();
    for (int a = 3; a < 9; a++) begin
      v = 8'($urandom);
      acc(1'b1, 8'(a), v, 12'h000);
      acc(1'b0, 8'(a), 8'h00, {4'h0, v});
      if (a > 4) check({4'h0, regs[a]}, {4'h0, v});
    end
    acc(1'b1, ST1, 8'hff, 12'h000);
    acc(1'b0, ST1, 8'h00, 12'h000);
    acc(1'b1, 8'h10, 8'h77, 12'h000);
    acc(1'b0, 8'h10, 8'h00, 12'h000);
    exp_q.push_back(12'he00);
    host_u.access(DEV ^ 7'h01, 1'b1, CFG, 8'h41);
    acc(1'b1, CFG, 8'h80, 12'h000);
    chk_dflt();
    acc(1'b0, 8'h3e, 8'h00, {4'h0, mcsr_pkg::ID_VALUE_A});
    acc(1'b1, 8'h20, 8'h3c, 12'h000);
    acc(1'b0, 8'h20, 8'h00, 12'h03c);
    v = 8'($urandom);
    v[0] = 1'b1;
    acc(1'b1, CFG, 8'h01, 12'h000);
    events(v[6:0], 1'b0);
    check(pins, 12'h002);
    acc(1'b0, ST1, 8'h00, {5'h01, v[6:0]});
    acc(1'b0, ST1, 8'h00, 12'h000);
    w = 8'($urandom);
    st2_set = w;
    encl = 1'b1;
    host_u.tick(4);
    st2_set = 8'h00;
    encl = 1'b0;
    host_u.tick(4);
    acc(1'b0, 8'h02, 8'h00, {4'h0, w | 8'h10});
    acc(1'b0, 8'h02, 8'h00, 12'h000);
    acc(1'b1, CFG, 8'h07, 12'h000);
    events(v[6:0], 1'b1);
    check(pins, 12'h00e);
    acc(1'b1, CFG, 8'h06, 12'h000);
    check(pins, 12'h00c);
    acc(1'b1, CFG, 8'h0f, 12'h000);
    events(~v[6:0], 1'b0);
    check(pins, 12'h004);
    acc(1'b1, CFG, 8'h03, 12'h000);
    check(pins, 12'h00a);
    acc(1'b0, ST1, 8'h00, {5'h00, v[6:0]});
    check(pins, 12'h002);
    acc(1'b1, CFG, 8'h40, 12'h000);
    check(pins, 12'h001);
    acc(1'b1, CFG, 8'h00, 12'h000);
    check(pins, 12'h000);
    pulse_case(8'h80, 8'h10, PULSE);
    pulse_case(8'hc0, 8'h10, 0);
    pulse_case(8'h14, 8'h10, 0);
    pulse_case(8'h14, 8'h20, PULSE);
    print_verdict();
  end
  initial begin
    host_u.tick(60000);
    n_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
